// ### rtl/mcms_consts.svh
// constants for the core memory and status block: addresses, reset values, field positions, sizes
`ifndef MCMS_CONSTS_SVH
`define MCMS_CONSTS_SVH

// machine cycle length in core clock periods
`define MCMS_MC_LEN 12
// storage sizes in bytes and their address widths in bits
`define MCMS_CODE_DEPTH 8192
`define MCMS_CODE_AW 13
`define MCMS_RAM_DEPTH 256
`define MCMS_RAM_AW 8
`define MCMS_NV_DEPTH 640
`define MCMS_NV_AW 10
// special-function addresses
`define MCMS_SFR_ACC 8'hE0
`define MCMS_SFR_AUX 8'hF0
`define MCMS_SFR_SP 8'h81
`define MCMS_SFR_DPL 8'h82
`define MCMS_SFR_DPH 8'h83
`define MCMS_SFR_PSW 8'hD0
`define MCMS_SFR_NV_CMD 8'hB9
`define MCMS_SFR_NV_DATA 8'hBC
`define MCMS_SFR_NV_ADL 8'hC6
`define MCMS_SFR_NV_ADH 8'hC7
// nonvolatile data commands written to the command register
`define MCMS_NV_CMD_READ 8'h01
`define MCMS_NV_CMD_WRITE 8'h02
// reset values
`define MCMS_SP_RST 8'h07
`define MCMS_PSW_RST 8'h00
`define MCMS_BYTE_RST 8'h00
// status word bit positions
`define MCMS_PSW_CY 7
`define MCMS_PSW_AC 6
`define MCMS_PSW_F0 5
`define MCMS_PSW_RS1 4
`define MCMS_PSW_RS0 3
`define MCMS_PSW_OV 2
`define MCMS_PSW_F1 1
`define MCMS_PSW_P 0
// high nibble of the byte addresses of the bit-addressable region
`define MCMS_BIT_BASE_HI 4'h2

`endif

// ### rtl/mcms_pkg.sv
// types for the core memory and status block
package mcms_pkg;

  // operations requested by the core
  typedef enum logic [4:0] {
    OP_DIR_RD = 5'h00,
    OP_DIR_WR = 5'h01,
    OP_IND_RD = 5'h02,
    OP_IND_WR = 5'h03,
    OP_REG_RD = 5'h04,
    OP_REG_WR = 5'h05,
    OP_BIT_RD = 5'h06,
    OP_BIT_WR = 5'h07,
    OP_PUSH = 5'h08,
    OP_POP = 5'h09,
    OP_ADD = 5'h0A,
    OP_SUB = 5'h0B,
    OP_MUL = 5'h0C,
    OP_DIV = 5'h0D,
    OP_PTR_LD = 5'h0E,
    OP_PTR_INC = 5'h0F,
    OP_CODE_RD = 5'h10
  } mcms_op_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BITMOD = 3'b010,
    ST_NVRD = 3'b100
  } mcms_state_t;

  // where the read answer comes from
  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_RAM = 2'h1,
    SRC_RAMBIT = 2'h2,
    SRC_CODE = 2'h3
  } mcms_src_t;

endpackage

// ### rtl/mcms_mem.sv
// single-port byte store with registered read data
module mcms_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_re) begin
      o_rdata <= mem[i_addr];
    end
  end

endmodule

// ### rtl/mcms_core.sv
// core memory organisation and core register set with status word
//
// Function
// [RULE1] Each machine cycle lasts exactly twelve core clock periods.
// [RULE2] There is no external program or data memory port; all accesses stay on chip.
// [RULE3] Instructions are fetched only from the on-chip eight-kilobyte program store.
// [RULE4] Data memory is lower RAM, upper RAM, special-function area and a 640-byte nonvolatile area.
// [RULE5] Lower RAM answers direct and indirect access, upper RAM only indirect, special area only direct.
// [RULE6] The nonvolatile data area is reached only through control registers in the special area.
// [RULE7] The lowest 32 bytes form four banks of eight working registers chosen by two status bits.
// [RULE8] Bytes 20H to 2FH are also addressable as 128 single bits at bit addresses 00H to 7FH.
// [RULE9] The stack may sit anywhere in internal RAM and grow up to 256 bytes.
// [RULE10] Reset loads the stack pointer with 07H so the first pushed byte lands at 08H.
// [RULE11] Push increments the stack pointer first and then writes the new location.
// [RULE12] The pointer bytes work as one 16-bit code pointer and as two separate 8-bit registers.
// [RULE13] The accumulator is operand and result for add, subtract, multiply, divide and bit operations; bit ops here use i_wdata[0] and o_rd_data instead.
// [RULE14] The auxiliary register pairs with the accumulator for multiply and divide, else is scratch.
// [RULE15] The status word sits at D0H, resets to 00H, is bit addressable and has the listed fields.
// [RULE16] The parity bit is even parity of the accumulator every cycle and ignores writes.
// [RULE17] Arithmetic updates carry, half carry and overflow; user flags change only by writes. Multiply and divide here leave half carry unchanged.
`include "mcms_consts.svh"

module mcms_core
  import mcms_pkg::*;
#(
  parameter int MC_LEN = `MCMS_MC_LEN,
  parameter int NV_DEPTH = `MCMS_NV_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_op_valid,
  input wire mcms_op_t i_op,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_use_carry,
  output logic o_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  input wire logic i_fetch_valid,
  input wire logic [`MCMS_CODE_AW-1:0] i_fetch_addr,
  output logic o_fetch_valid,
  output logic [7:0] o_fetch_data,
  input wire logic i_code_load,
  input wire logic [`MCMS_CODE_AW-1:0] i_code_load_addr,
  input wire logic [7:0] i_code_load_data,
  output logic o_mc_tick,
  output logic [3:0] o_mc_phase,
  output logic [7:0] o_accumulator_reg,
  output logic [7:0] o_aux_operand,
  output logic [7:0] o_stack_top_pointer,
  output logic [15:0] o_code_address_pointer,
  output logic [7:0] o_processor_status_word
);

  // register state
  logic [3:0] mc_cnt_r;
  logic [7:0] acc_r, acc_nxt, aux_r, aux_nxt, sp_r, sp_nxt;
  logic [7:0] code_pointer_high_r, code_pointer_high_nxt, code_pointer_low_r, code_pointer_low_nxt;
  logic [7:1] psw_r, psw_nxt;
  logic [7:0] nv_data_r, nv_data_nxt, nv_adl_r, nv_adl_nxt;
  logic [1:0] nv_adh_r, nv_adh_nxt;
  mcms_state_t state_r, state_nxt;
  mcms_src_t rd_src_r, rd_src_nxt;
  logic [7:0] rd_reg_r, rd_reg_nxt;
  logic [2:0] rd_bit_r, rd_bit_nxt;
  logic rd_valid_nxt;
  logic [7:0] mod_addr_r, mod_addr_nxt;
  logic [2:0] mod_bit_r, mod_bit_nxt;
  logic mod_val_r, mod_val_nxt;
  // memory ports
  logic ram_we, ram_re;
  logic [7:0] ram_addr, ram_wdata, ram_q;
  logic code_re;
  logic [`MCMS_CODE_AW-1:0] code_addr;
  logic [7:0] code_q;
  logic nv_we, nv_re;
  logic [7:0] nv_q;
  // special-area write request
  logic sfr_we;
  logic [7:0] sfr_waddr, sfr_wval;

  // special-area read mux; unmapped addresses read as zero
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    unique case (a)
      `MCMS_SFR_ACC: sfr_read = acc_r;
      `MCMS_SFR_AUX: sfr_read = aux_r;
      `MCMS_SFR_SP: sfr_read = sp_r;
      `MCMS_SFR_DPL: sfr_read = code_pointer_low_r;
      `MCMS_SFR_DPH: sfr_read = code_pointer_high_r;
      `MCMS_SFR_PSW: sfr_read = o_processor_status_word;
      `MCMS_SFR_NV_DATA: sfr_read = nv_data_r;
      `MCMS_SFR_NV_ADL: sfr_read = nv_adl_r;
      `MCMS_SFR_NV_ADH: sfr_read = {6'h00, nv_adh_r};
      default: sfr_read = `MCMS_BYTE_RST;
    endcase
  endfunction

  // decode of the incoming request
  wire accept = i_op_valid && o_ready;
  wire is_upper = i_addr[7];
  wire [1:0] bank = psw_r[`MCMS_PSW_RS1:`MCMS_PSW_RS0];
  wire [7:0] reg_addr = {3'b000, bank, i_addr[2:0]}; // [RULE7]
  wire [7:0] bit_byte = is_upper ? {i_addr[7:3], 3'b000} : {`MCMS_BIT_BASE_HI, i_addr[6:3]}; // [RULE8]
  wire [2:0] bit_idx = i_addr[2:0];
  logic [7:0] sfr_bit_src;
  // a process, not an assign, so register changes seen inside the lookup re-evaluate it
  always_comb sfr_bit_src = sfr_read(bit_byte);
  wire [7:0] sfr_bit_mod = (sfr_bit_src & ~(8'h01 << bit_idx)) | ({7'h00, i_wdata[0]} << bit_idx);
  wire [7:0] ram_bit_mod = (ram_q & ~(8'h01 << mod_bit_r)) | ({7'h00, mod_val_r} << mod_bit_r);
  wire [7:0] sp_inc = sp_r + 8'h01;
  wire [7:0] sp_dec = sp_r - 8'h01;
  wire [15:0] ptr = {code_pointer_high_r, code_pointer_low_r}; // [RULE12]
  wire [15:0] ptr_inc = ptr + 16'h0001;
  wire [`MCMS_NV_AW-1:0] nv_addr = {nv_adh_r, nv_adl_r};
  wire nv_in_range = 32'(nv_addr) < NV_DEPTH;

  // arithmetic datapath around the accumulator
  wire cin = i_use_carry & psw_r[`MCMS_PSW_CY];
  wire [8:0] add_sum = {1'b0, acc_r} + {1'b0, i_wdata} + {8'h00, cin}; // [RULE13]
  wire [4:0] add_lo = {1'b0, acc_r[3:0]} + {1'b0, i_wdata[3:0]} + {4'h0, cin};
  wire add_ov = (acc_r[7] == i_wdata[7]) && (add_sum[7] != acc_r[7]);
  wire [8:0] sub_dif = {1'b0, acc_r} - {1'b0, i_wdata} - {8'h00, cin};
  wire [4:0] sub_lo = {1'b0, acc_r[3:0]} - {1'b0, i_wdata[3:0]} - {4'h0, cin};
  wire sub_ov = (acc_r[7] != i_wdata[7]) && (sub_dif[7] != acc_r[7]);
  wire [15:0] prod = {8'h00, acc_r} * {8'h00, aux_r}; // [RULE14]
  wire div_zero = aux_r == 8'h00;
  // guard the divider so a zero divisor never reaches it
  wire [7:0] div_by = div_zero ? 8'h01 : aux_r;
  wire [7:0] quo = acc_r / div_by;
  wire [7:0] rem = acc_r % div_by;

  // special-area writes from direct writes and from bit writes above 7FH
  assign sfr_we = accept && is_upper && ((i_op == OP_DIR_WR) || (i_op == OP_BIT_WR)); // [RULE5]
  assign sfr_waddr = (i_op == OP_BIT_WR) ? bit_byte : i_addr;
  assign sfr_wval = (i_op == OP_BIT_WR) ? sfr_bit_mod : i_wdata;
  wire nv_cmd_wr = sfr_we && (sfr_waddr == `MCMS_SFR_NV_CMD);
  // out-of-range nonvolatile addresses are silently ignored
  assign nv_re = nv_cmd_wr && (sfr_wval == `MCMS_NV_CMD_READ) && nv_in_range; // [RULE6]
  assign nv_we = nv_cmd_wr && (sfr_wval == `MCMS_NV_CMD_WRITE) && nv_in_range; // [RULE6]

  // code store port: loading wins, then instruction fetch, then pointer reads
  assign code_addr = i_code_load ? i_code_load_addr : (i_fetch_valid ? i_fetch_addr : ptr[`MCMS_CODE_AW-1:0]);
  assign code_re = !i_code_load && (i_fetch_valid || (accept && (i_op == OP_CODE_RD))); // [RULE3]

  // one request per cycle; pointer code reads wait while the code port is busy
  assign o_ready = (state_r == ST_IDLE) && !((i_fetch_valid || i_code_load) && (i_op == OP_CODE_RD));

  // request sequencer and register next values
  always_comb begin
    acc_nxt = acc_r;
    aux_nxt = aux_r;
    sp_nxt = sp_r;
    code_pointer_high_nxt = code_pointer_high_r;
    code_pointer_low_nxt = code_pointer_low_r;
    psw_nxt = psw_r;
    nv_data_nxt = nv_data_r;
    nv_adl_nxt = nv_adl_r;
    nv_adh_nxt = nv_adh_r;
    state_nxt = state_r;
    rd_src_nxt = rd_src_r;
    rd_reg_nxt = rd_reg_r;
    rd_bit_nxt = rd_bit_r;
    rd_valid_nxt = 1'b0;
    mod_addr_nxt = mod_addr_r;
    mod_bit_nxt = mod_bit_r;
    mod_val_nxt = mod_val_r;
    ram_we = 1'b0;
    ram_re = 1'b0;
    ram_addr = i_addr;
    ram_wdata = i_wdata;
    if (sfr_we) begin
      unique case (sfr_waddr)
        `MCMS_SFR_ACC: acc_nxt = sfr_wval;
        `MCMS_SFR_AUX: aux_nxt = sfr_wval;
        `MCMS_SFR_SP: sp_nxt = sfr_wval;
        `MCMS_SFR_DPL: code_pointer_low_nxt = sfr_wval;
        `MCMS_SFR_DPH: code_pointer_high_nxt = sfr_wval;
        `MCMS_SFR_PSW: psw_nxt = sfr_wval[7:1]; // [RULE15] [RULE16]
        `MCMS_SFR_NV_DATA: nv_data_nxt = sfr_wval;
        `MCMS_SFR_NV_ADL: nv_adl_nxt = sfr_wval;
        `MCMS_SFR_NV_ADH: nv_adh_nxt = sfr_wval[1:0];
        default: ;
      endcase
    end
    if (nv_re) begin
      state_nxt = ST_NVRD;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          rd_src_nxt = SRC_RAM;
          unique case (i_op)
            OP_DIR_RD: begin
              rd_valid_nxt = 1'b1;
              if (is_upper) begin
                rd_src_nxt = SRC_REG;
                rd_reg_nxt = sfr_read(i_addr); // [RULE5]
              end else begin
                ram_re = 1'b1;
              end
            end
            OP_DIR_WR: ram_we = !is_upper; // [RULE5]
            OP_IND_RD: begin
              ram_re = 1'b1; // [RULE5]
              rd_valid_nxt = 1'b1;
            end
            OP_IND_WR: ram_we = 1'b1; // [RULE5]
            OP_REG_RD: begin
              ram_addr = reg_addr;
              ram_re = 1'b1;
              rd_valid_nxt = 1'b1;
            end
            OP_REG_WR: begin
              ram_addr = reg_addr; // [RULE7]
              ram_we = 1'b1;
            end
            OP_BIT_RD: begin
              rd_valid_nxt = 1'b1;
              rd_bit_nxt = bit_idx;
              ram_addr = bit_byte;
              if (is_upper) begin
                rd_src_nxt = SRC_REG;
                rd_reg_nxt = {7'h00, sfr_bit_src[bit_idx]};
              end else begin
                rd_src_nxt = SRC_RAMBIT;
                ram_re = 1'b1; // [RULE8]
              end
            end
            OP_BIT_WR: begin
              // lower bits need a read-modify-write of the holding byte
              if (!is_upper) begin
                ram_addr = bit_byte;
                ram_re = 1'b1;
                mod_addr_nxt = bit_byte;
                mod_bit_nxt = bit_idx;
                mod_val_nxt = i_wdata[0];
                state_nxt = ST_BITMOD; // [RULE8]
              end
            end
            OP_PUSH: begin
              sp_nxt = sp_inc; // [RULE11]
              ram_addr = sp_inc; // [RULE9] [RULE11]
              ram_we = 1'b1;
            end
            OP_POP: begin
              sp_nxt = sp_dec;
              ram_addr = sp_r; // [RULE9]
              ram_re = 1'b1;
              rd_valid_nxt = 1'b1;
            end
            OP_ADD: begin
              acc_nxt = add_sum[7:0]; // [RULE13]
              psw_nxt[`MCMS_PSW_CY] = add_sum[8]; // [RULE17]
              psw_nxt[`MCMS_PSW_AC] = add_lo[4]; // [RULE17]
              psw_nxt[`MCMS_PSW_OV] = add_ov; // [RULE17]
            end
            OP_SUB: begin
              acc_nxt = sub_dif[7:0]; // [RULE13]
              psw_nxt[`MCMS_PSW_CY] = sub_dif[8]; // [RULE17]
              psw_nxt[`MCMS_PSW_AC] = sub_lo[4]; // [RULE17]
              psw_nxt[`MCMS_PSW_OV] = sub_ov; // [RULE17]
            end
            OP_MUL: begin
              acc_nxt = prod[7:0]; // [RULE13] [RULE14]
              aux_nxt = prod[15:8]; // [RULE14]
              psw_nxt[`MCMS_PSW_CY] = 1'b0; // [RULE17]
              psw_nxt[`MCMS_PSW_OV] = prod[15:8] != 8'h00; // [RULE17]
            end
            OP_DIV: begin
              // a zero divisor leaves both operands untouched and flags overflow
              if (!div_zero) begin
                acc_nxt = quo; // [RULE13] [RULE14]
                aux_nxt = rem; // [RULE14]
              end
              psw_nxt[`MCMS_PSW_CY] = 1'b0; // [RULE17]
              psw_nxt[`MCMS_PSW_OV] = div_zero; // [RULE17]
            end
            OP_PTR_LD: begin
              code_pointer_high_nxt = i_addr; // [RULE12]
              code_pointer_low_nxt = i_wdata; // [RULE12]
            end
            OP_PTR_INC: begin
              code_pointer_high_nxt = ptr_inc[15:8]; // [RULE12]
              code_pointer_low_nxt = ptr_inc[7:0];
            end
            OP_CODE_RD: begin
              rd_src_nxt = SRC_CODE; // [RULE2] [RULE3]
              rd_valid_nxt = 1'b1;
            end
            default: ;
          endcase
        end
      end
      ST_BITMOD: begin
        ram_addr = mod_addr_r;
        ram_wdata = ram_bit_mod; // [RULE8]
        ram_we = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_NVRD: begin
        nv_data_nxt = nv_q; // [RULE6]
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // machine cycle divider: one tick every twelve core clocks
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mc_cnt_r <= 4'h0;
    end else begin
      mc_cnt_r <= (mc_cnt_r == 4'(MC_LEN - 1)) ? 4'h0 : mc_cnt_r + 4'h1; // [RULE1]
    end
  end

  // core registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_r <= `MCMS_BYTE_RST;
      aux_r <= `MCMS_BYTE_RST;
      sp_r <= `MCMS_SP_RST; // [RULE10]
      code_pointer_high_r <= `MCMS_BYTE_RST;
      code_pointer_low_r <= `MCMS_BYTE_RST;
      psw_r <= 7'(`MCMS_PSW_RST >> 1); // [RULE15]
      nv_data_r <= `MCMS_BYTE_RST;
      nv_adl_r <= `MCMS_BYTE_RST;
      nv_adh_r <= 2'h0;
    end else begin
      acc_r <= acc_nxt;
      aux_r <= aux_nxt;
      sp_r <= sp_nxt;
      code_pointer_high_r <= code_pointer_high_nxt;
      code_pointer_low_r <= code_pointer_low_nxt;
      psw_r <= psw_nxt;
      nv_data_r <= nv_data_nxt;
      nv_adl_r <= nv_adl_nxt;
      nv_adh_r <= nv_adh_nxt;
    end
  end

  // sequencer and read-answer tracking
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      rd_src_r <= SRC_REG;
      rd_reg_r <= `MCMS_BYTE_RST;
      rd_bit_r <= 3'h0;
      o_rd_valid <= 1'b0;
      o_fetch_valid <= 1'b0;
      mod_addr_r <= `MCMS_BYTE_RST;
      mod_bit_r <= 3'h0;
      mod_val_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rd_src_r <= rd_src_nxt;
      rd_reg_r <= rd_reg_nxt;
      rd_bit_r <= rd_bit_nxt;
      o_rd_valid <= rd_valid_nxt;
      o_fetch_valid <= i_fetch_valid && !i_code_load; // [RULE3]
      mod_addr_r <= mod_addr_nxt;
      mod_bit_r <= mod_bit_nxt;
      mod_val_r <= mod_val_nxt;
    end
  end

  // 256 bytes: lower half direct or indirect, upper half indirect only
  mcms_mem #(.DW(8), .DEPTH(`MCMS_RAM_DEPTH), .AW(`MCMS_RAM_AW)) u_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(ram_we),
    .i_re(ram_re),
    .i_addr(ram_addr),
    .i_wdata(ram_wdata),
    .o_rdata(ram_q)
  ); // [RULE4]

  mcms_mem #(.DW(8), .DEPTH(`MCMS_CODE_DEPTH), .AW(`MCMS_CODE_AW)) u_code (
    .i_clk_sys(i_clk_sys),
    .i_we(i_code_load),
    .i_re(code_re),
    .i_addr(code_addr),
    .i_wdata(i_code_load_data),
    .o_rdata(code_q)
  ); // [RULE3]

  mcms_mem #(.DW(8), .DEPTH(`MCMS_NV_DEPTH), .AW(`MCMS_NV_AW)) u_nv (
    .i_clk_sys(i_clk_sys),
    .i_we(nv_we),
    .i_re(nv_re),
    .i_addr(nv_addr),
    .i_wdata(nv_data_r),
    .o_rdata(nv_q)
  ); // [RULE4] [RULE6]

  // answers are selected among registered sources only
  assign o_rd_data = (rd_src_r == SRC_RAM) ? ram_q :
                     (rd_src_r == SRC_RAMBIT) ? {7'h00, ram_q[rd_bit_r]} :
                     (rd_src_r == SRC_CODE) ? code_q : rd_reg_r;
  assign o_fetch_data = code_q;
  assign o_mc_tick = mc_cnt_r == 4'(MC_LEN - 1); // [RULE1]
  assign o_mc_phase = mc_cnt_r;
  assign o_accumulator_reg = acc_r;
  assign o_aux_operand = aux_r;
  assign o_stack_top_pointer = sp_r;
  assign o_code_address_pointer = ptr;
  // parity is live from the accumulator, never stored
  assign o_processor_status_word = {psw_r, ^acc_r}; // [RULE15] [RULE16]

endmodule

// ### dv/mcms_core_chk.sv
// assertion checker for the core memory and status block
module mcms_core_chk
  import mcms_pkg::*;
#(
  parameter int MC_LEN = 12
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_op_valid,
  input wire mcms_op_t i_op,
  input wire logic i_fetch_valid,
  input wire logic i_code_load,
  input wire logic o_ready,
  input wire logic o_rd_valid,
  input wire logic o_fetch_valid,
  input wire logic o_mc_tick,
  input wire logic [3:0] o_mc_phase,
  input wire logic [7:0] o_accumulator_reg,
  input wire logic [7:0] o_stack_top_pointer,
  input wire logic [15:0] o_code_address_pointer,
  input wire logic [7:0] o_processor_status_word
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // request decode; o_ready is combinational so take is the real hand-off
  wire logic take = i_op_valid && o_ready;
  wire logic rd_op = i_op inside {OP_DIR_RD, OP_IND_RD, OP_REG_RD, OP_BIT_RD, OP_POP, OP_CODE_RD};
  wire logic arith = i_op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV};
  wire logic [3:0] last_ph = 4'(MC_LEN - 1);

  AST_TICK_PHASE: assert property (o_mc_tick == (o_mc_phase == last_ph))
    else $error("tick off last phase");
  AST_PHASE_WRAP: assert property (o_mc_phase == last_ph |=> o_mc_phase == 4'h0)
    else $error("phase did not wrap");
  AST_PHASE_STEP: assert property (o_mc_phase != last_ph |=> o_mc_phase == $past(o_mc_phase) + 4'h1)
    else $error("phase did not step");
  AST_TICK_GAP: assert property (o_mc_tick |=> !o_mc_tick [*8])
    else $error("tick too soon");
  AST_PARITY: assert property (o_processor_status_word[0] == ^o_accumulator_reg)
    else $error("parity bit wrong");
  AST_PUSH_INC: assert property (take && i_op == OP_PUSH |=> o_stack_top_pointer == $past(o_stack_top_pointer) + 8'h01)
    else $error("push did not bump pointer");
  AST_READ_ANS: assert property (take && rd_op |=> o_rd_valid)
    else $error("read not answered");
  AST_RD_ONLY: assert property (o_rd_valid |-> $past(take && rd_op))
    else $error("answer without read");
  AST_FETCH: assert property (i_fetch_valid && !i_code_load |=> o_fetch_valid)
    else $error("fetch not answered");
  AST_PTR_INC: assert property (take && i_op == OP_PTR_INC |=> o_code_address_pointer == $past(o_code_address_pointer) + 16'h0001)
    else $error("pointer did not step");
  AST_USER_FLAGS: assert property (take && arith |=> $stable(o_processor_status_word[5]) && $stable(o_processor_status_word[1]))
    else $error("user flag moved");
endmodule

bind mcms_core mcms_core_chk #(.MC_LEN(MC_LEN)) mcms_core_chk_inst (.i_clk_sys, .i_rst_n, .i_op_valid, .i_op,
  .i_fetch_valid, .i_code_load, .o_ready, .o_rd_valid, .o_fetch_valid, .o_mc_tick, .o_mc_phase, .o_accumulator_reg,
  .o_stack_top_pointer, .o_code_address_pointer, .o_processor_status_word);

// ### dv/mcms_core_tb_top.sv
// self-checking bench for the core memory and status block
module mcms_core_tb_top
  import mcms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_op_valid = 1'b0;
  logic i_use_carry = 1'b0;
  logic i_fetch_valid = 1'b0;
  logic i_code_load = 1'b0;
  mcms_op_t i_op = OP_DIR_RD;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_code_load_data = 8'h00;
  logic [12:0] i_fetch_addr = 13'h0000;
  logic [12:0] i_code_load_addr = 13'h0000;
  logic o_ready, o_rd_valid, o_fetch_valid, o_mc_tick;
  logic [3:0] o_mc_phase;
  logic [7:0] o_rd_data, o_fetch_data, o_accumulator_reg, o_aux_operand, o_stack_top_pointer;
  logic [7:0] o_processor_status_word, rd;
  logic [15:0] o_code_address_pointer;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ticks;

  mcms_core mcms_core_inst (.i_clk_sys, .i_rst_n, .i_op_valid, .i_op, .i_addr, .i_wdata, .i_use_carry, .o_ready,
    .o_rd_valid, .o_rd_data, .i_fetch_valid, .i_fetch_addr, .o_fetch_valid, .o_fetch_data, .i_code_load,
    .i_code_load_addr, .i_code_load_data, .o_mc_tick, .o_mc_phase, .o_accumulator_reg, .o_aux_operand,
    .o_stack_top_pointer, .o_code_address_pointer, .o_processor_status_word);

  // 40 MHz core clock
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // hang guard, far above the under two hundred cycles the sequence needs
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held from a falling edge until taken; answer caught one cycle on
  task automatic xfer(input mcms_op_t op, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge i_clk_sys);
    i_op_valid = 1'b1;
    i_op = op;
    i_addr = a;
    i_wdata = d;
    n = 0;
    while (o_ready !== 1'b1 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n == 20) begin
      miscompares++;
    end
    @(negedge i_clk_sys);
    i_op_valid = 1'b0;
    rd = o_rd_valid ? o_rd_data : 8'hXX;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    xfer(OP_DIR_WR, a, d);
  endtask

  task automatic rx(input mcms_op_t op, input logic [7:0] a, input logic [7:0] e);
    xfer(op, a, 8'h00);
    chk($sformatf("rd %s %h", op.name(), a), {8'h00, e}, {8'h00, rd});
  endtask

  task automatic load_fetch(input logic [12:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_code_load = 1'b1;
    i_code_load_addr = a;
    i_code_load_data = d;
    @(negedge i_clk_sys);
    i_code_load = 1'b0;
    i_fetch_valid = 1'b1;
    i_fetch_addr = a;
    @(negedge i_clk_sys);
    i_fetch_valid = 1'b0;
    chk("fetch", {7'h00, 1'b1, d}, {7'h00, o_fetch_valid, o_fetch_data});
  endtask

  initial begin
    repeat (10) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    // reset state of the register set
    chk("sp", 16'h0007, {8'h00, o_stack_top_pointer});
    chk("psw", 16'h0000, {8'h00, o_processor_status_word});
    chk("acc aux", 16'h0000, {o_accumulator_reg, o_aux_operand});
    chk("ptr", 16'h0000, o_code_address_pointer);
    rx(OP_DIR_RD, 8'hD0, 8'h00);
    // first push lands on bank one register zero
    xfer(OP_PUSH, 8'h00, 8'h55);
    chk("sp", 16'h0008, {8'h00, o_stack_top_pointer});
    w(8'hD0, 8'h08);
    rx(OP_REG_RD, 8'h00, 8'h55);
    rx(OP_POP, 8'h00, 8'h55);
    chk("sp", 16'h0007, {8'h00, o_stack_top_pointer});
    // all four banks, each via its select code
    for (int b = 0; b < 4; b++) begin
      w(8'hD0, 8'(b << 3));
      xfer(OP_REG_WR, 8'(b + 1), 8'(8'hA0 + b));
      rx(OP_IND_RD, 8'(b * 9 + 1), 8'(8'hA0 + b));
    end
    // direct and indirect views of lower RAM, upper RAM and special area
    w(8'h30, 8'h12);
    rx(OP_IND_RD, 8'h30, 8'h12);
    xfer(OP_IND_WR, 8'hE0, 8'h77);
    w(8'hE0, 8'h96);
    rx(OP_DIR_RD, 8'hE0, 8'h96);
    rx(OP_IND_RD, 8'hE0, 8'h77);
    rx(OP_DIR_RD, 8'h84, 8'h00);
    // parity tracks acc, write to bit 0 dropped
    w(8'hD0, 8'hE7);
    chk("psw", 16'h00E6, {8'h00, o_processor_status_word});
    w(8'hE0, 8'h07);
    chk("psw", 16'h00E7, {8'h00, o_processor_status_word});
    // bit space: top edge of the region, an inner bit and a status bit
    w(8'h21, 8'h00);
    w(8'h2F, 8'h00);
    xfer(OP_BIT_WR, 8'h0B, 8'h01);
    xfer(OP_BIT_WR, 8'h7F, 8'h01);
    rx(OP_DIR_RD, 8'h21, 8'h08);
    rx(OP_DIR_RD, 8'h2F, 8'h80);
    rx(OP_BIT_RD, 8'h0B, 8'h01);
    xfer(OP_BIT_WR, 8'hD5, 8'h00);
    chk("psw", 16'h00C7, {8'h00, o_processor_status_word});
    // arithmetic flags with both user flags set
    w(8'hE0, 8'h7F);
    w(8'hD0, 8'h22);
    xfer(OP_ADD, 8'h00, 8'h01);
    chk("add", 16'h8067, {o_accumulator_reg, o_processor_status_word});
    xfer(OP_SUB, 8'h00, 8'h01);
    chk("sub", 16'h7F67, {o_accumulator_reg, o_processor_status_word});
    xfer(OP_ADD, 8'h00, 8'h81);
    i_use_carry = 1'b1;
    xfer(OP_ADD, 8'h00, 8'h00);
    i_use_carry = 1'b0;
    chk("adc", 16'h0001, {8'h00, o_accumulator_reg});
    w(8'hF0, 8'h10);
    w(8'hE0, 8'h20);
    xfer(OP_MUL, 8'h00, 8'h00);
    chk("mul", 16'h0002, {o_accumulator_reg, o_aux_operand});
    chk("mul ov", 16'h0001, {15'h0000, o_processor_status_word[2]});
    w(8'hE0, 8'h64);
    w(8'hF0, 8'h07);
    xfer(OP_DIV, 8'h00, 8'h00);
    chk("div", 16'h0E02, {o_accumulator_reg, o_aux_operand});
    w(8'hF0, 8'h00);
    xfer(OP_DIV, 8'h00, 8'h00);
    chk("div0", 16'h0E01, {o_accumulator_reg, 7'h00, o_processor_status_word[2]});
    // pointer as one word and as two bytes
    xfer(OP_PTR_LD, 8'h12, 8'hFF);
    xfer(OP_PTR_INC, 8'h00, 8'h00);
    chk("ptr", 16'h1300, o_code_address_pointer);
    rx(OP_DIR_RD, 8'h83, 8'h13);
    w(8'h82, 8'h34);
    chk("ptr", 16'h1334, o_code_address_pointer);
    // last byte of the 8K code store, by fetch and by pointer
    load_fetch(13'h1FFF, 8'hA5);
    xfer(OP_PTR_LD, 8'h1F, 8'hFF);
    rx(OP_CODE_RD, 8'h00, 8'hA5);
    // nonvolatile area at its last byte, through the control registers
    w(8'hC6, 8'h7F);
    w(8'hC7, 8'h02);
    w(8'hBC, 8'hC3);
    w(8'hB9, 8'h02);
    w(8'hBC, 8'h00);
    w(8'hB9, 8'h01);
    rx(OP_DIR_RD, 8'hBC, 8'hC3);
    // stack running past the top of the space
    w(8'h81, 8'hFF);
    xfer(OP_PUSH, 8'h00, 8'h5A);
    rx(OP_IND_RD, 8'h00, 8'h5A);
    // two machine cycles in 24 clocks
    ticks = 0;
    repeat (24) begin
      @(negedge i_clk_sys);
      ticks += int'(o_mc_tick);
    end
    chk("ticks", 16'h0002, 16'(ticks));
    // reset in mid-run
    i_rst_n = 1'b0;
    @(negedge i_clk_sys);
    chk("sp psw", 16'h0700, {o_stack_top_pointer, o_processor_status_word});
    i_rst_n = 1'b1;
    @(negedge i_clk_sys);
    wrap_up();
  end
endmodule
